// >>> src/hsp_pkg.sv
// Package with shared constants and carrier types for the host SRAM-like port.
package hsp_pkg;

  localparam int unsigned HSP_DATA_W      = 16;
  localparam int unsigned HSP_ADDR_W      = 7;
  localparam int unsigned HSP_FIFO_DEPTH  = 16;
  localparam int unsigned HSP_STRAP_W     = 4;
  localparam int unsigned HSP_CLK_NS      = 10;
  localparam int unsigned HSP_TCSH_NS     = 13;
  localparam int unsigned HSP_TCSH_CYC    = (HSP_TCSH_NS + HSP_CLK_NS - 1) / HSP_CLK_NS;
  localparam int unsigned HSP_WIDX_LSB    = 1;
  localparam int unsigned HSP_WIDX_MSB    = 2;
  localparam logic [15:0] HSP_RD_IDLE     = 16'h0000;
  localparam logic [1:0]  HSP_WIDX_RST    = 2'h0;

  // Host pin group sampled each clock.
  typedef struct packed {
    logic                  chip_select_low;
    logic                  read_strobe_low;
    logic                  write_strobe_low;
    logic                  fifo_direct_sel;
    logic [HSP_ADDR_W:1]   addr;
    logic [HSP_DATA_W-1:0] data_in;
  } hsp_pins_type;

  // Register write leaving the port when the direct select is low.
  typedef struct packed {
    logic                  valid;
    logic [HSP_ADDR_W:1]   addr;
    logic [HSP_DATA_W-1:0] data;
  } hsp_regwr_type;

endpackage : hsp_pkg

// >>> src/hsp_fifo.sv
// Synchronous valid/ready FIFO parameterised by width and depth.
module hsp_fifo
  import hsp_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
)(
  input  wire logic             clk_sys,  // System clock.
  input  wire logic             rst_n,    // Asynchronous reset, active low.
  input  wire logic             in_valid, // Fill side offers a word.
  output logic                  in_ready, // FIFO has room.
  input  wire logic [WIDTH-1:0] in_data,  // Word to store.
  output logic                  out_valid,// FIFO holds a word.
  input  wire logic             out_ready,// Drain side takes the word.
  output logic [WIDTH-1:0]      out_data  // Oldest word.
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } hsp_fifo_st_type;

  hsp_fifo_st_type          st_ff;
  hsp_fifo_st_type          nxt_st;
  logic [WIDTH-1:0]         mem_ff [DEPTH];
  logic                     do_push;
  logic                     do_pop;

  // Handshake terms; full and empty come from the occupancy count.
  assign in_ready  = (st_ff.count != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.count != '0);
  assign out_data  = mem_ff[st_ff.rd_ptr];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  // Next pointer and count values.
  always_comb
  begin
    nxt_st = st_ff;
    if (do_push)
    begin
      nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(DEPTH-1)) ? '0 : st_ff.wr_ptr + 1'b1;
    end
    if (do_pop)
    begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(DEPTH-1)) ? '0 : st_ff.rd_ptr + 1'b1;
    end
    nxt_st.count = st_ff.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Storage array, written on a push.
  always_ff @(posedge clk_sys)
  begin
    if (do_push)
    begin
      mem_ff[st_ff.wr_ptr] <= in_data;
    end
  end

  chk_fifo_no_overrun : assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.count <= (AW+1)'(DEPTH))
    else $error("FIFO count exceeds depth.");

endmodule : hsp_fifo

// >>> src/hsp_port.sv
// Host SRAM-like port: strobe framing, direct FIFO writes and reads, strap capture.
// Behaviour
// - Read cycle spans both strobes low.
// - One write protocol for registers and FIFOs.
// - Write begins both low, ends either high.
// - Direct select writes go to transmit FIFO.
// - Direct writes use ordinary write protocol.
// - Direct select reads return receive FIFO data.
// - Direct modes keep word bits, ignore upper.
// - Direct burst reads may run unlimited.
module hsp_port
  import hsp_pkg::*;
#(
  parameter int unsigned DATA_W     = HSP_DATA_W,
  parameter int unsigned FIFO_DEPTH = HSP_FIFO_DEPTH
)(
  input  wire logic                  clk_sys,          // System clock, 100 MHz.
  input  wire logic                  rst_n,            // Asynchronous reset, active low.
  input  wire logic                  reset_pin_low,    // Host reset pin level, active low.
  input  wire logic [HSP_STRAP_W-1:0] strap_in,        // Configuration strap inputs.
  output logic [HSP_STRAP_W-1:0]     strap_q,          // Straps caught at reset release.
  input  wire logic                  chip_select_low,  // Host chip select, active low.
  input  wire logic                  read_strobe_low,  // Host read strobe, active low.
  input  wire logic                  write_strobe_low, // Host write strobe, active low.
  input  wire logic                  fifo_direct_sel,  // Direct FIFO access select.
  input  wire logic [HSP_ADDR_W:1]   addr,             // Host word address.
  input  wire logic [DATA_W-1:0]     data_in,          // Host data bus, input side.
  output logic [DATA_W-1:0]          data_out,         // Host data bus, output side.
  output logic                       data_oe,          // Drive enable for the data bus.
  output logic [1:0]                 rd_word_idx,      // Word index of the current read, direct or register.
  output logic                       reg_wr_valid,     // Register write pulse.
  output logic [HSP_ADDR_W:1]        reg_wr_addr,      // Register write address.
  output logic [DATA_W-1:0]          reg_wr_data,      // Register write data.
  output logic                       reg_rd_active,    // Non-direct read in progress.
  input  wire logic [DATA_W-1:0]     reg_rd_data,      // Register read data.
  output logic                       tx_valid,         // Transmit FIFO holds a word.
  input  wire logic                  tx_ready,         // Transmit side takes a word.
  output logic [DATA_W-1:0]          tx_data,          // Oldest transmit word.
  output logic                       tx_full,          // Transmit FIFO has no room.
  input  wire logic                  rx_valid,         // Receive data word available.
  input  wire logic [DATA_W-1:0]     rx_data,          // Receive data word.
  output logic                       rx_pop            // Receive word consumed.
);

  // All port state in one record.
  typedef struct packed {
    logic                  wr_act;
    logic                  wr_dir;
    logic [HSP_ADDR_W:1]   wr_addr;
    logic [DATA_W-1:0]     wr_data;
    logic                  rd_act;
    logic                  rd_dir;
    logic [DATA_W-1:0]     rd_q;
    logic [1:0]            widx;
    logic                  rst_seen;
    logic [HSP_STRAP_W-1:0] straps;
    logic                  rw_valid;
    logic                  tx_push;
    logic [DATA_W-1:0]     tx_word;
  } hsp_st_type;

  hsp_st_type    st_ff;
  hsp_st_type    nxt_st;
  hsp_pins_type  pins;
  logic          wr_on;
  logic          rd_on;
  logic          wr_end;
  logic          rd_start;
  logic          fifo_in_ready;

  // Word-address bits kept in direct modes; bits above are dropped.
  function automatic logic [1:0] word_idx(input logic [HSP_ADDR_W:1] a);
    word_idx = a[HSP_WIDX_MSB:HSP_WIDX_LSB];
  endfunction : word_idx

  // Pin grouping and cycle framing.
  assign pins     = '{chip_select_low, read_strobe_low, write_strobe_low, fifo_direct_sel, addr, data_in};
  assign wr_on    = !pins.chip_select_low && !pins.write_strobe_low;
  assign rd_on    = !pins.chip_select_low && !pins.read_strobe_low;
  assign wr_end   = st_ff.wr_act && !wr_on;
  assign rd_start = rd_on && !st_ff.rd_act;

  // Next-state logic for write capture, reads and strap sampling.
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.rw_valid = 1'b0;
    nxt_st.tx_push  = st_ff.tx_push && !fifo_in_ready;
    nxt_st.wr_act   = wr_on;
    if (wr_on)
    begin
      // Data tracks the bus while asserted so the last value before release is kept.
      nxt_st.wr_data = pins.data_in;
      nxt_st.wr_addr = pins.addr;
      nxt_st.wr_dir  = pins.fifo_direct_sel;
    end
    if (wr_end)
    begin
      if (st_ff.wr_dir)
      begin
        nxt_st.tx_push = 1'b1;
        nxt_st.tx_word = st_ff.wr_data;
      end
      else
      begin
        nxt_st.rw_valid = 1'b1;
      end
    end
    nxt_st.rd_act = rd_on;
    if (rd_start)
    begin
      nxt_st.rd_dir = pins.fifo_direct_sel;
      nxt_st.widx   = word_idx(pins.addr);
      nxt_st.rd_q   = pins.fifo_direct_sel ? (rx_valid ? rx_data : DATA_W'(HSP_RD_IDLE)) : reg_rd_data;
    end
    else if (rd_on && !st_ff.rd_dir)
    begin
      nxt_st.rd_q = reg_rd_data;
    end
    // Straps follow the pins while reset is held and freeze at its release.
    nxt_st.rst_seen = reset_pin_low; // Pin level at the last edge, for the release check.
    if (!reset_pin_low)
    begin
      nxt_st.straps = strap_in;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '{default: '0, widx: HSP_WIDX_RST, rd_q: HSP_RD_IDLE};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Transmit buffer; a push waits while the FIFO is full.
  hsp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (st_ff.tx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (st_ff.tx_word),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // Outputs; each direct read cycle with a receive word pops one word, so bursts run without limit.
  assign tx_full       = !fifo_in_ready;
  assign rx_pop        = rd_start && pins.fifo_direct_sel && rx_valid;
  assign data_out      = st_ff.rd_q;
  assign data_oe       = st_ff.rd_act;
  assign rd_word_idx   = st_ff.widx;
  assign reg_wr_valid  = st_ff.rw_valid;
  assign reg_wr_addr   = st_ff.wr_addr;
  assign reg_wr_data   = st_ff.wr_data;
  assign reg_rd_active = st_ff.rd_act && !st_ff.rd_dir;
  assign strap_q       = st_ff.straps;

  // Cycle-end events, split by where the written word goes.
  sequence s_dir_release;
    st_ff.wr_act && !wr_on && st_ff.wr_dir;
  endsequence

  sequence s_reg_release;
    st_ff.wr_act && !wr_on && !st_ff.wr_dir;
  endsequence

  chk_write_end_push : assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_dir_release |=> st_ff.tx_push && st_ff.tx_word == $past(st_ff.wr_data))
    else $error("Direct write did not push the captured word.");
  chk_write_reg_pulse : assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_reg_release |=> reg_wr_valid ##1 !reg_wr_valid)
    else $error("Register write pulse missing or too long.");
  chk_write_no_pulse : assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr_valid |-> $past(st_ff.wr_act) && !$past(wr_on))
    else $error("Register write without a cycle end.");
  chk_read_drive : assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_on |=> data_oe)
    else $error("Data bus not driven during read.");
  chk_read_release : assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rd_on |=> !data_oe)
    else $error("Data bus driven outside read.");
  chk_direct_pop : assert property (@(posedge clk_sys) disable iff (!rst_n)
    rx_pop |=> data_out == $past(rx_data) && rd_word_idx == $past(addr[2:1]))
    else $error("Direct read data or word index wrong.");
  chk_burst_pops : assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_on && !st_ff.rd_act && fifo_direct_sel && rx_valid |-> rx_pop)
    else $error("Direct burst read did not pop.");
  chk_strap_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.rst_seen && reset_pin_low |=> $stable(strap_q))
    else $error("Straps changed after reset release.");

  // Straps follow the pins one edge later while the host holds reset.
  chk_strap_follow : assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reset_pin_low |=> strap_q == $past(strap_in))
    else $error("Straps did not follow the pins during reset.");

  // A push refused by a full FIFO stays pending until room appears.
  chk_tx_wait : assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff.tx_push && tx_full |=> st_ff.tx_push)
    else $error("Pending transmit word was dropped.");

  // The write word is the last one seen with both strobes low.
  chk_write_capture : assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_on |=> st_ff.wr_data == $past(data_in))
    else $error("Write data not tracked during the cycle.");

  // Every read start latches the word index, whatever the upper bits hold.
  chk_read_index : assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_start |=> rd_word_idx == $past(addr[2:1]))
    else $error("Read word index not latched at start.");

  // A register read keeps following the register data while it lasts.
  chk_reg_read_follow : assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_on && st_ff.rd_act && !st_ff.rd_dir |=> data_out == $past(reg_rd_data))
    else $error("Register read data not refreshed.");

endmodule : hsp_port

// >>> dv/hsp_host_model.sv
// Host memory bus model that frames write and read cycles with the strobes.
module hsp_host_model
  import hsp_pkg::*;
(
  input  wire logic        clk_sys,          // System clock.
  output logic             chip_select_low,  // Chip select.
  output logic             read_strobe_low,  // Read strobe.
  output logic             write_strobe_low, // Write strobe.
  output logic             fifo_direct_sel,  // Direct select.
  output logic [7:1]       addr,             // Word address.
  output logic [15:0]      data_in,          // Write data.
  input  wire logic [15:0] data_out,         // Read data.
  input  wire logic        data_oe           // Read drive enable.
);
  timeunit 1ns;
  timeprecision 1ps;
  bit flip;

  // Bus idles with all strobes high.
  initial
  begin
    {chip_select_low, read_strobe_low, write_strobe_low} = 3'h7;
    fifo_direct_sel = 1'b0;
    addr = 7'h00;
    data_in = 16'h0000;
  end

  // Ends a cycle by lifting one strobe first, in alternating order, then keeps all high.
  task automatic end_cycle();
    if (flip)
      {read_strobe_low, write_strobe_low} <= 2'h3;
    else
      chip_select_low <= 1'b1;
    flip = !flip;
    @(posedge clk_sys);
    {chip_select_low, read_strobe_low, write_strobe_low} <= 3'h7;
    fifo_direct_sel <= !fifo_direct_sel;
    addr <= ~addr;
    data_in <= ~data_in;
    repeat (HSP_TCSH_CYC) @(posedge clk_sys);
  endtask : end_cycle

  // Write cycle: strobes low for two edges with steady select, address and data.
  task automatic write(input logic sel, input logic [7:1] a, input logic [15:0] d);
    @(posedge clk_sys);
    fifo_direct_sel <= sel;
    addr <= a;
    data_in <= d;
    {chip_select_low, write_strobe_low} <= 2'h0;
    repeat (2) @(posedge clk_sys);
    end_cycle();
  endtask : write

  // Read cycle: the answer is taken at the third edge with both strobes low.
  task automatic read(input logic sel, input logic [7:1] a, output logic [15:0] q, output logic oe);
    @(posedge clk_sys);
    fifo_direct_sel <= sel;
    addr <= a;
    {chip_select_low, read_strobe_low} <= 2'h0;
    repeat (3) @(posedge clk_sys);
    q = data_out;
    oe = data_oe;
    end_cycle();
  endtask : read
endmodule : hsp_host_model

// >>> dv/tb_hsp_port.sv
// Self-checking bench for the host port: writes, FIFO fill and drain, direct reads, straps.
module tb_hsp_port
  import hsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_sys, rst_n, reset_pin_low, tx_ready, rx_valid, stall, oe;
  logic                chip_select_low, read_strobe_low, write_strobe_low, fifo_direct_sel;
  logic                data_oe, reg_wr_valid, reg_rd_active, tx_valid, tx_full, rx_pop;
  logic [3:0]          strap_in, strap_q;
  logic [7:1]          addr, reg_wr_addr, a;
  logic [15:0]         data_in, data_out, reg_wr_data, reg_rd_data, tx_data, rx_data, rnd, d, q;
  logic [1:0]          rd_word_idx;
  logic [22:0]         e;
  logic [22:0]         reg_q[$];
  logic [15:0]         tx_q[$];
  int                  fail_count;
  int                  checks;

  hsp_port u_hsp_port (.clk_sys, .rst_n, .reset_pin_low, .strap_in, .strap_q, .chip_select_low,
    .read_strobe_low, .write_strobe_low, .fifo_direct_sel, .addr, .data_in, .data_out, .data_oe,
    .rd_word_idx, .reg_wr_valid, .reg_wr_addr, .reg_wr_data, .reg_rd_active, .reg_rd_data,
    .tx_valid, .tx_ready, .tx_data, .tx_full, .rx_valid, .rx_data, .rx_pop);
  hsp_host_model u_hsp_host_model (.clk_sys, .chip_select_low, .read_strobe_low,
    .write_strobe_low, .fifo_direct_sel, .addr, .data_in, .data_out, .data_oe);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Random source, stalling transmit drain and a receive word stream that advances on pop.
  always @(posedge clk_sys)
  begin
    rnd <= lfsr(rnd);
    tx_ready <= !stall && rnd[0];
    if (rx_pop)
      rx_data <= lfsr(rx_data);
  end

  // Takes the oldest note whenever a transmit word or a register write leaves the port.
  always @(posedge clk_sys)
  begin
    if (rst_n && tx_valid && tx_ready)
      chk("tx_data", tx_q.size() > 0 ? tx_q.pop_front() : 16'hxxxx, tx_data);
    if (rst_n && data_oe)
      chk("reg_rd_active", {15'h0000, !fifo_direct_sel}, {15'h0000, reg_rd_active});
    if (rst_n && reg_wr_valid)
    begin
      e = reg_q.size() > 0 ? reg_q.pop_front() : 23'h7fffff;
      chk("reg_wr_addr", {9'h000, e[22:16]}, {9'h000, reg_wr_addr});
      chk("reg_wr_data", e[15:0], reg_wr_data);
    end
  end

  // Cuts a hang short.
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    reset_pin_low = 1'b0;
    strap_in = 4'ha;
    stall = 1'b1;
    tx_ready = 1'b0;
    rx_valid = 1'b1;
    rx_data = 16'h00a5;
    reg_rd_data = 16'h0000;
    rnd = 16'h1400;
    fail_count = 0;
    checks = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    reset_pin_low <= 1'b1;
    @(posedge clk_sys);
    strap_in <= 4'h5;
    repeat (3) @(posedge clk_sys);
    chk("strap_q", 16'h000a, {12'h000, strap_q});
    // Register writes, then direct writes into a stalled FIFO past full, so one push waits.
    for (int i = 0; i < 21; i++)
    begin
      d = rnd;
      if (i < 4)
        reg_q.push_back({rnd[15:9], d});
      else
        tx_q.push_back(d);
      u_hsp_host_model.write(i >= 4, rnd[15:9], d);
    end
    repeat (2) @(posedge clk_sys);
    chk("tx_full", 16'h0001, {15'h0000, tx_full});
    stall <= 1'b0;
    for (int n = 0; n < 400 && tx_q.size() > 0; n++)
      @(posedge clk_sys);
    if (tx_q.size() > 0 || reg_q.size() > 0)
    begin
      fail_count++;
      tally_and_finish();
    end
    // Direct reads with random upper address, one with no receive word, then a register read.
    for (int i = 0; i < 22; i++)
    begin
      d = (i == 20) ? 16'h0000 : (i == 21) ? rnd : rx_data;
      rx_valid <= (i != 20);
      a = rnd[15:9];
      reg_rd_data <= rnd;
      u_hsp_host_model.read(i != 21, a, q, oe);
      chk("read_data", d, q);
      chk("data_oe", 16'h0001, {15'h0000, oe});
      chk("rd_word_idx", {14'h0000, a[2:1]}, {14'h0000, rd_word_idx});
      chk("data_oe_idle", 16'h0000, {15'h0000, data_oe});
    end
    tally_and_finish();
  end
endmodule : tb_hsp_port
